// File: hw/plc_pkg.sv
package plc_pkg;
	// register map, byte wide registers on a 10-bit address
	localparam logic [9:0] PLC_ADDR_LOCK_CAL = 10'h018;
	localparam logic [9:0] PLC_ADDR_SYNC_CTRL = 10'h019;
	localparam logic [9:0] PLC_ADDR_STATUS = 10'h01f;
	localparam logic [9:0] PLC_ADDR_TRANSFER = 10'h232;
	// field positions in the lock and calibration control register
	localparam int PLC_CAL_START_BIT = 0;
	localparam int PLC_CAL_DIV_LSB = 1;
	localparam int PLC_LD_DISABLE_BIT = 3;
	localparam int PLC_WIN_RANGE_BIT = 4;
	localparam int PLC_LOCK_CNT_LSB = 5;
	// field positions in the sync control and transfer registers
	localparam int PLC_SYNC_MODE_LSB = 6;
	localparam int PLC_TRANSFER_BIT = 0;
	// values after reset
	localparam logic [7:0] PLC_LOCK_CAL_RST = 8'h00;
	localparam logic [7:0] PLC_SYNC_CTRL_RST = 8'h00;
	// high range window time, in picoseconds
	localparam int PLC_WINDOW_HIGH_PS = 3500;
	// consecutive phase detector cycles needed before lock is shown
	localparam logic [7:0] PLC_LOCK_CNT_0 = 8'h05;
	localparam logic [7:0] PLC_LOCK_CNT_1 = 8'h10;
	localparam logic [7:0] PLC_LOCK_CNT_2 = 8'h40;
	localparam logic [7:0] PLC_LOCK_CNT_3 = 8'hff;
	// calibration clock divide ratios for the two documented encodings
	localparam logic [3:0] PLC_CAL_DIV_00 = 4'h2;
	localparam logic [3:0] PLC_CAL_DIV_10 = 4'h8;

	typedef enum logic [1:0] {
		PLC_SYNC_NONE,
		PLC_SYNC_ASYNC,
		PLC_SYNC_SYNC,
		PLC_SYNC_IGNORE
	} plc_sync_mode_t;

	// one host register access
	typedef struct packed {
		logic wr;
		logic [9:0] addr;
		logic [7:0] wdata;
	} plc_reg_req_t;

	// phase detector comparison results from the analog edge comparators
	typedef struct packed {
		logic cycle;
		logic in_window;
		logic past_unlock;
	} plc_pfd_t;
endpackage

// File: hw/plc_top.sv
`timescale 1ns/10ps
module plc_top import plc_pkg::*; #(
	parameter logic [3:0] CAL_DIV_01 = 4'h0,
	parameter logic [3:0] CAL_DIV_11 = 4'h0
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire plc_reg_req_t REG_REQ,
	input wire logic [9:0] REG_RADDR,
	output logic [7:0] REG_RDATA,
	input wire plc_pfd_t PHASE_FREQUENCY_DETECTOR,
	input wire logic SYNC,
	output logic WINDOW_LOW_RANGE,
	output logic WINDOW_FLAG,
	output logic DIGITAL_LOCK_INDICATOR,
	output logic CAL_CLK,
	output logic CAL_START,
	output logic CNT_RESET_ASYNC,
	output logic CNT_RESET_SYNC
);
	logic rst_meta_q;
	logic rst_n_q;
	logic [7:0] buf_lock_cal_q;
	logic [7:0] buf_sync_q;
	logic [7:0] act_lock_cal_q;
	logic [7:0] act_sync_q;
	logic transfer;
	logic cal_start_prev_q;
	logic cal_start_q;
	logic win_flag_q;
	logic [7:0] lock_cnt_q;
	logic [7:0] lock_need;
	logic dld_q;
	logic [3:0] cal_div;
	logic [2:0] cal_cnt_q;
	logic cal_clk_q;
	logic sync_rst_q;
	logic [7:0] rdata_q;
	logic ld_disable;
	plc_sync_mode_t sync_mode;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// transfer bit is self clearing: only the write pulse acts
	assign transfer = REG_REQ.wr && (REG_REQ.addr == PLC_ADDR_TRANSFER)
		&& REG_REQ.wdata[PLC_TRANSFER_BIT];

	// host writes go to the buffered copies only
	always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			buf_lock_cal_q <= PLC_LOCK_CAL_RST;
			buf_sync_q <= PLC_SYNC_CTRL_RST;
		end else if (REG_REQ.wr) begin
			if (REG_REQ.addr == PLC_ADDR_LOCK_CAL) begin
				buf_lock_cal_q <= REG_REQ.wdata;
			end
			if (REG_REQ.addr == PLC_ADDR_SYNC_CTRL) begin
				buf_sync_q <= REG_REQ.wdata;
			end
		end
	end

	// whole buffered set copied at once so settings change together
	always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			act_lock_cal_q <= PLC_LOCK_CAL_RST;
			act_sync_q <= PLC_SYNC_CTRL_RST;
		end else if (transfer) begin
			act_lock_cal_q <= buf_lock_cal_q;
			act_sync_q <= buf_sync_q;
		end
	end

	assign ld_disable = act_lock_cal_q[PLC_LD_DISABLE_BIT];
	assign sync_mode = plc_sync_mode_t'(act_sync_q[PLC_SYNC_MODE_LSB +: 2]);

	// edge of the active bit, so a buffered-only change never starts one
	always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cal_start_prev_q <= 1'b0;
			cal_start_q <= 1'b0;
		end else begin
			cal_start_prev_q <= act_lock_cal_q[PLC_CAL_START_BIT];
			cal_start_q <= act_lock_cal_q[PLC_CAL_START_BIT] && !cal_start_prev_q;
		end
	end

	// range select drives the analog window comparator, 0 is the high range
	always_comb begin
		WINDOW_LOW_RANGE = act_lock_cal_q[PLC_WIN_RANGE_BIT];
	end

	// hysteresis flag: set inside window, held until past unlock threshold
	always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			win_flag_q <= 1'b0;
		end else if (ld_disable) begin
			win_flag_q <= 1'b0;
		end else if (PHASE_FREQUENCY_DETECTOR.cycle) begin
			if (PHASE_FREQUENCY_DETECTOR.in_window) begin
				win_flag_q <= 1'b1;
			end else if (PHASE_FREQUENCY_DETECTOR.past_unlock) begin
				win_flag_q <= 1'b0;
			end
		end
	end

	// required consecutive cycle count
	always_comb begin
		unique case (act_lock_cal_q[PLC_LOCK_CNT_LSB +: 2])
			2'h0: lock_need = PLC_LOCK_CNT_0;
			2'h1: lock_need = PLC_LOCK_CNT_1;
			2'h2: lock_need = PLC_LOCK_CNT_2;
			2'h3: lock_need = PLC_LOCK_CNT_3;
		endcase
	end

	// count in-window cycles; any cycle outside restarts the run
	always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lock_cnt_q <= 8'h00;
			dld_q <= 1'b0;
		end else if (ld_disable) begin
			lock_cnt_q <= 8'h00;
			dld_q <= 1'b0;
		end else if (PHASE_FREQUENCY_DETECTOR.cycle) begin
			if (PHASE_FREQUENCY_DETECTOR.in_window) begin
				if (lock_cnt_q != 8'hff) begin
					lock_cnt_q <= lock_cnt_q + 8'h01;
				end
				if (lock_cnt_q + 8'h01 >= lock_need) begin
					dld_q <= 1'b1;
				end
			end else begin
				lock_cnt_q <= 8'h00;
				if (!win_flag_q || PHASE_FREQUENCY_DETECTOR.past_unlock) begin
					dld_q <= 1'b0;
				end
			end
		end
	end

	// divide ratio; zero halts the clock for unconfirmed encodings
	always_comb begin
		unique case (act_lock_cal_q[PLC_CAL_DIV_LSB +: 2])
			2'h0: cal_div = PLC_CAL_DIV_00;
			2'h1: cal_div = CAL_DIV_01;
			2'h2: cal_div = PLC_CAL_DIV_10;
			2'h3: cal_div = CAL_DIV_11;
		endcase
	end

	// toggles every half period; odd ratios round the half period down
	always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cal_cnt_q <= 3'h0;
			cal_clk_q <= 1'b0;
		end else if (cal_div < 4'h2) begin
			cal_cnt_q <= 3'h0;
			cal_clk_q <= 1'b0;
		end else if ({1'b0, cal_cnt_q} + 4'h1 >= {1'b0, cal_div[3:1]}) begin
			cal_cnt_q <= 3'h0;
			cal_clk_q <= !cal_clk_q;
		end else begin
			cal_cnt_q <= cal_cnt_q + 3'h1;
		end
	end

	// synchronous counter reset waits for the clock edge
	always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync_rst_q <= 1'b0;
		end else begin
			sync_rst_q <= SYNC && (sync_mode == PLC_SYNC_SYNC);
		end
	end

	// read back buffered values and live status; unmapped reads give zero
	always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= 8'h00;
		end else begin
			unique case (REG_RADDR)
				PLC_ADDR_LOCK_CAL: rdata_q <= buf_lock_cal_q;
				PLC_ADDR_SYNC_CTRL: rdata_q <= buf_sync_q;
				PLC_ADDR_STATUS: rdata_q <= {6'h00, win_flag_q, dld_q};
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	assign REG_RDATA = rdata_q;
	assign WINDOW_FLAG = win_flag_q;
	assign DIGITAL_LOCK_INDICATOR = dld_q;
	assign CAL_CLK = cal_clk_q;
	assign CAL_START = cal_start_q;
	// asynchronous reset must follow the pin without a clock, so it is gated, not registered
	assign CNT_RESET_ASYNC = SYNC && (sync_mode == PLC_SYNC_ASYNC);
	assign CNT_RESET_SYNC = sync_rst_q;
endmodule

// File: verification/plc_props.sv
`timescale 1ns/10ps
// lock and sync outputs against their causes; calibration start as a single pulse
module plc_props import plc_pkg::*; (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire plc_pfd_t PHASE_FREQUENCY_DETECTOR,
	input wire logic SYNC,
	input wire logic WINDOW_FLAG,
	input wire logic DIGITAL_LOCK_INDICATOR,
	input wire logic CAL_START,
	input wire logic CNT_RESET_ASYNC,
	input wire logic CNT_RESET_SYNC
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	logic [7:0] run_q;
	// in-window run length, saturating so a long lock never wraps to zero
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			run_q <= 8'h00;
		end else if (PHASE_FREQUENCY_DETECTOR.cycle) begin
			run_q <= !PHASE_FREQUENCY_DETECTOR.in_window ? 8'h00 : (run_q == 8'hff ? run_q : run_q + 8'h01);
		end
	end
	sequence s_one_pulse;
		CAL_START ##1 !CAL_START;
	endsequence
	chk_lock_run: assert property ($rose(DIGITAL_LOCK_INDICATOR) |-> run_q >= PLC_LOCK_CNT_0)
		else $error("lock shown too early");
	chk_lock_flag: assert property (DIGITAL_LOCK_INDICATOR |-> WINDOW_FLAG)
		else $error("lock without window flag");
	chk_lock_fall: assert property ($fell(DIGITAL_LOCK_INDICATOR) |-> $past(PHASE_FREQUENCY_DETECTOR.cycle))
		else $error("lock dropped without compare");
	chk_flag_cause: assert property ($rose(WINDOW_FLAG) |-> $past(PHASE_FREQUENCY_DETECTOR.cycle && PHASE_FREQUENCY_DETECTOR.in_window))
		else $error("flag set without in-window compare");
	chk_flag_hold: assert property ($fell(WINDOW_FLAG) |-> $past(PHASE_FREQUENCY_DETECTOR.cycle))
		else $error("flag dropped without compare");
	chk_start_once: assert property ($rose(CAL_START) |-> s_one_pulse)
		else $error("start not a single pulse");
	chk_async_src: assert property (CNT_RESET_ASYNC |-> SYNC)
		else $error("async reset without sync");
	chk_sync_late: assert property (CNT_RESET_SYNC |-> $past(SYNC))
		else $error("sync reset without sync");
	chk_sync_excl: assert property (!(CNT_RESET_ASYNC && CNT_RESET_SYNC))
		else $error("both counter resets");
endmodule

// File: verification/plc_host_model.sv
`timescale 1ns/10ps
// host on the register port; changes requests only at the falling edge
module plc_host_model import plc_pkg::*; (
	input wire logic CLK_SYS,
	output plc_reg_req_t REG_REQ,
	output logic [9:0] REG_RADDR,
	input wire logic [7:0] REG_RDATA
);
	initial begin
		REG_REQ = '0;
		REG_RADDR = '0;
	end
	// idle cycle after each write so the strobe is never lowered and raised at once
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		REG_REQ = '{1'b1, a, d};
		@(negedge CLK_SYS);
		REG_REQ = '0;
		@(negedge CLK_SYS);
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		REG_RADDR = a;
		@(negedge CLK_SYS);
		d = REG_RDATA;
	endtask
	// start bit cleared and transferred first so the active start bit always rises
	task automatic cal(input logic [7:0] cfg);
		wr(PLC_ADDR_LOCK_CAL, cfg & 8'hfe);
		wr(PLC_ADDR_TRANSFER, 8'h01);
		wr(PLC_ADDR_LOCK_CAL, cfg | 8'h01);
		wr(PLC_ADDR_TRANSFER, 8'h01);
	endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top import plc_pkg::*;;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic sync = 1'b0;
	plc_pfd_t phase_frequency_detector = '0;
	plc_reg_req_t req;
	logic [9:0] raddr;
	logic [7:0] rdata;
	logic [7:0] d;
	logic wlr, flag, dli, cclk, cst, cra, crs;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	int lens[4] = '{PLC_LOCK_CNT_0, PLC_LOCK_CNT_1, PLC_LOCK_CNT_2, PLC_LOCK_CNT_3};
	logic [7:0] hts[2] = '{8'(PLC_CAL_DIV_00 >> 1), 8'(PLC_CAL_DIV_10 >> 1)};
	always #20 clk = ~clk;
	plc_host_model plc_host_model_i(.CLK_SYS(clk), .REG_REQ(req), .REG_RADDR(raddr),
		.REG_RDATA(rdata));
	plc_top plc_top_i(.CLK_SYS(clk), .RSTN(rstn), .REG_REQ(req), .REG_RADDR(raddr),
		.REG_RDATA(rdata), .PHASE_FREQUENCY_DETECTOR(phase_frequency_detector), .SYNC(sync), .WINDOW_LOW_RANGE(wlr), .WINDOW_FLAG(flag),
		.DIGITAL_LOCK_INDICATOR(dli), .CAL_CLK(cclk), .CAL_START(cst),
		.CNT_RESET_ASYNC(cra), .CNT_RESET_SYNC(crs));
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// a hang is cut short well past the longest lock run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			final_report;
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			$display("[FAIL] %s exp %h got %h", nm, e, s);
			n_errors++;
		end
	endtask
	task automatic rdc(input logic [9:0] a, input logic [7:0] e);
		plc_host_model_i.rd(a, d);
		chk("rdata", e, d);
	endtask
	task automatic xfer;
		plc_host_model_i.wr(PLC_ADDR_TRANSFER, 8'h01);
	endtask
	task automatic pfd_run(input logic w, input logic u, input int k);
		repeat (k) begin
			phase_frequency_detector = '{1'b1, w, u};
			@(negedge clk);
		end
		phase_frequency_detector = '0;
		@(negedge clk);
	endtask
	// cycles until the calibration clock next changes, bounded
	task automatic flip(output int c);
		logic v;
		v = cclk;
		c = 0;
		while (cclk === v && c < 20) begin
			@(negedge clk);
			c++;
		end
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		rdc(PLC_ADDR_LOCK_CAL, PLC_LOCK_CAL_RST);
		rdc(PLC_ADDR_SYNC_CTRL, PLC_SYNC_CTRL_RST);
		rdc(PLC_ADDR_TRANSFER, 8'h00);
		rdc(10'h100, 8'h00);
		plc_host_model_i.wr(PLC_ADDR_LOCK_CAL, 8'h10);
		chk("range", 8'h00, {7'h0, wlr});
		rdc(PLC_ADDR_LOCK_CAL, 8'h10);
		xfer;
		chk("range", 8'h01, {7'h0, wlr});
		// one start pulse per sequence, then the divider half period
		for (int i = 0; i < 2; i++) begin
			plc_host_model_i.cal({5'h0, 1'(i), 2'h0});
			n = 0;
			// the pulse already stands when the task returns, so sample before waiting
			repeat (8) begin
				n += (cst === 1'b1);
				@(negedge clk);
			end
			chk("cal_start", 8'h01, 8'(n));
			flip(n);
			flip(n);
			chk("cal_clk", hts[i], 8'(n));
		end
		xfer;
		repeat (8) begin
			chk("cal_start", 8'h00, {7'h0, cst});
			@(negedge clk);
		end
		foreach (lens[k]) begin
			plc_host_model_i.wr(PLC_ADDR_LOCK_CAL, {1'b0, 2'(k), 5'h0});
			xfer;
			pfd_run(1'b0, 1'b1, 1);
			pfd_run(1'b1, 1'b0, lens[k] - 1);
			chk("lock", 8'h00, {7'h0, dli});
			pfd_run(1'b1, 1'b0, 1);
			chk("lock", 8'h01, {7'h0, dli});
		end
		rdc(PLC_ADDR_STATUS, 8'h03);
		pfd_run(1'b0, 1'b0, 1);
		chk("flag", 8'h01, {7'h0, flag});
		pfd_run(1'b0, 1'b1, 1);
		chk("flag", 8'h00, {7'h0, flag});
		plc_host_model_i.wr(PLC_ADDR_LOCK_CAL, 8'h08);
		xfer;
		pfd_run(1'b1, 1'b0, 6);
		chk("flag", 8'h00, {6'h0, flag, dli});
		for (int m = 0; m < 4; m++) begin
			plc_host_model_i.wr(PLC_ADDR_SYNC_CTRL, {2'(m), 6'h0});
			xfer;
			sync = 1'b1;
			@(negedge clk);
			chk("async", {7'h0, m == 1}, {7'h0, cra});
			@(negedge clk);
			chk("sync", {7'h0, m == 2}, {7'h0, crs});
			sync = 1'b0;
			@(negedge clk);
		end
		final_report;
	end
endmodule
bind plc_top plc_props plc_props_i(.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PHASE_FREQUENCY_DETECTOR(PHASE_FREQUENCY_DETECTOR), .SYNC(SYNC),
	.WINDOW_FLAG(WINDOW_FLAG), .DIGITAL_LOCK_INDICATOR(DIGITAL_LOCK_INDICATOR),
	.CAL_START(CAL_START), .CNT_RESET_ASYNC(CNT_RESET_ASYNC), .CNT_RESET_SYNC(CNT_RESET_SYNC));
